// ===== pid_loop_control.sv
`timescale 1ns/10ps
`include "pid_cfg.svh"
module pid_loop_control #(
    parameter int SAMPLE_CYCLES = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS,
    parameter int NUM_TERMS     = 5
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                run_cmd,
    input  wire logic [NUM_TERMS-1:0] term_pins,
    input  wire logic signed [15:0]  reference,
    input  wire logic signed [15:0]  feedback,
    input  wire logic signed [15:0]  general_freq,
    output logic signed [15:0]       freq_cmd,
    output logic                     output_block,
    output logic                     prestage_timeout_fault,
    output logic                     sleeping,
    output logic [7:0]               reference_source_select,
    output logic [7:0]               feedback_source_select
);
    import pid_pkg::*;
    initial if (SAMPLE_CYCLES < 2 || NUM_TERMS < 1 || NUM_TERMS > 5) begin
        $error("pid_loop_control parameters out of range");
    end

    // ****************************************
    // Registers and terminal inputs
    // ****************************************
    reg_bank_t              regs;
    logic [31:0]            status;
    logic [NUM_TERMS-1:0]   terms;

    reg_slave u_regs (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .status        (status),
        .regs          (regs)
    );

    term_sync #(.W(NUM_TERMS)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (term_pins),
        .levels  (terms)
    );

    // True when any active terminal carries the given function code
    function automatic logic term_on(input logic [5:0] code,
                                     input logic [NUM_TERMS-1:0] lv,
                                     input logic [31:0] map);
        term_on = 1'b0;
        for (int t = 0; t < NUM_TERMS; t++) begin
            if (lv[t] && map[`TERM_FUNC_W*t +: `TERM_FUNC_W] == code) begin
                term_on = 1'b1;
            end
        end
    endfunction

    logic i_clear;
    logic bypass;
    logic alt_sel;
    assign i_clear = term_on(`FUNC_I_CLEAR, terms, regs[`IDX_TERM_FUNC]);
    assign bypass  = term_on(`FUNC_BYPASS, terms, regs[`IDX_TERM_FUNC]);
    assign alt_sel = term_on(`FUNC_ALT_GAIN, terms, regs[`IDX_TERM_FUNC]);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        loop_state_e        state;
        logic [31:0]        tick_cnt;
        logic [15:0]        cnt;
        logic signed [47:0] acc;
        logic signed [16:0] err_prev;
        logic signed [31:0] filt;
        logic signed [15:0] freq;
        logic signed [15:0] pid_out;
    } loop_s;

    loop_s q;
    loop_s d;

    // ****************************************
    // Controller arithmetic
    // ****************************************
    logic               tick;
    logic               loop_en;
    logic signed [16:0] err;
    logic [15:0]        kp_eff;
    logic [15:0]        ti_eff;
    logic signed [63:0] p_t;
    logic signed [63:0] i_t;
    logic signed [63:0] d_t;
    logic signed [63:0] f_t;
    logic signed [63:0] sum;
    logic signed [63:0] filt_n;
    logic signed [63:0] hi;
    logic signed [63:0] lo;
    logic signed [63:0] lim;
    logic signed [63:0] scaled;
    logic               clamped;
    logic               wake;

    assign tick    = (q.tick_cnt == 32'(SAMPLE_CYCLES - 1));
    assign loop_en = (regs[`IDX_APP][15:0] == `APP_PROCESS) && !bypass;
    assign err     = 17'(reference) - 17'(feedback);
    assign kp_eff  = alt_sel ? regs[`IDX_ALT_GAIN][15:0] : regs[`IDX_KP][15:0];
    assign ti_eff  = alt_sel ? regs[`IDX_ALT_TI][15:0] : regs[`IDX_TI][15:0];
    // Gain in 0.1 percent, further scaled in percent
    assign p_t = 64'(err) * $signed({48'h0, kp_eff}) * $signed({48'h0, regs[`IDX_KP_SCALE][15:0]})
                 / (`GAIN_DEN * `KP_SCALE_DEN);
    // One sample per ms: sum of errors over integral time ms
    assign i_t = (ti_eff == 16'h0000) ? 64'sh0
                 : 64'(q.acc) / $signed({48'h0, ti_eff});
    assign d_t = (64'(err) - 64'(q.err_prev)) * $signed({48'h0, regs[`IDX_TD][15:0]});
    assign f_t = 64'(reference) * $signed({48'h0, regs[`IDX_FF][15:0]}) / `GAIN_DEN;
    assign sum = p_t + i_t + d_t + f_t;
    assign filt_n = 64'(q.filt) + ((sum - 64'(q.filt)) >>> regs[`IDX_LPF][3:0]);
    assign hi  = 64'($signed(regs[`IDX_HI][15:0]));
    assign lo  = 64'($signed(regs[`IDX_LO][15:0]));
    assign lim = (filt_n > hi) ? hi : ((filt_n < lo) ? lo : filt_n);
    assign clamped = (sum > hi) || (sum < lo);
    assign scaled = lim * $signed({48'h0, regs[`IDX_OUT_SCALE][15:0]}) / `GAIN_DEN;

    always_comb begin
        case (regs[`IDX_WAKE_MODE][1:0])
            `WAKE_BELOW:  wake = feedback < $signed(regs[`IDX_WAKE_LEVEL][15:0]);
            `WAKE_ABOVE:  wake = feedback > $signed(regs[`IDX_WAKE_LEVEL][15:0]);
            `WAKE_BEYOND: wake = err > 17'($signed(regs[`IDX_WAKE_LEVEL][15:0]));
            default:      wake = 1'b0;
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        d = q;
        d.tick_cnt = tick ? 32'h00000000 : q.tick_cnt + 32'h00000001;
        if (q.state != ST_RUN) begin
            d.acc = '0;
        end
        if (!run_cmd) begin
            d.state = ST_IDLE;
            d.freq  = '0;
            d.cnt   = '0;
            d.filt  = '0;
        end else begin
            case (q.state)
                ST_IDLE: begin
                    d.cnt   = '0;
                    d.state = loop_en ? ST_PRESTAGE : ST_GENERAL;
                end
                ST_GENERAL: begin
                    d.freq = general_freq;
                    if (loop_en) begin
                        d.state = ST_RUN;
                        d.filt  = '0;
                        d.cnt   = '0;
                    end
                end
                ST_PRESTAGE: begin
                    d.freq = $signed(regs[`IDX_PRE_FREQ][15:0]);
                    if (!loop_en) begin
                        d.state = ST_GENERAL;
                    end else if (feedback > $signed(regs[`IDX_PRE_EXIT][15:0])) begin
                        d.state = ST_RUN;
                        d.cnt   = '0;
                    end else if (tick && regs[`IDX_PRE_DELAY][15:0] != 16'h0000) begin
                        d.cnt = q.cnt + 16'h0001;
                        if (q.cnt + 16'h0001 >= regs[`IDX_PRE_DELAY][15:0]) begin
                            d.state = ST_FAULT;
                            d.freq  = '0;
                        end
                    end
                end
                ST_RUN: begin
                    if (!loop_en) begin
                        d.state = ST_GENERAL;
                    end else if (tick) begin
                        d.err_prev = err;
                        d.filt     = 32'(filt_n);
                        d.pid_out  = 16'(lim);
                        d.freq     = 16'(scaled);
                        if (i_clear) begin
                            d.acc = '0;
                        end else if (!clamped) begin
                            d.acc = q.acc + 48'(err);
                        end
                        if (q.freq < $signed(regs[`IDX_SLEEP_FREQ][15:0]) &&
                            regs[`IDX_SLEEP_DELAY][15:0] != 16'h0000) begin
                            d.cnt = q.cnt + 16'h0001;
                            if (q.cnt + 16'h0001 >= regs[`IDX_SLEEP_DELAY][15:0]) begin
                                d.state = ST_SLEEP;
                                d.freq  = '0;
                                d.cnt   = '0;
                            end
                        end else begin
                            d.cnt = '0;
                        end
                    end
                end
                ST_SLEEP: begin
                    d.freq = '0;
                    if (!loop_en) begin
                        d.state = ST_GENERAL;
                    end else if (wake) begin
                        d.state = ST_RUN;
                        d.filt  = '0;
                    end
                end
                ST_FAULT: begin
                    // Held until the run command drops
                    d.freq = '0;
                end
                default: begin
                    d.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign freq_cmd               = q.freq;
    assign output_block           = (q.state == ST_FAULT);
    assign prestage_timeout_fault = (q.state == ST_FAULT);
    assign sleeping               = (q.state == ST_SLEEP);
    assign reference_source_select = regs[`IDX_REF_SRC][7:0];
    assign feedback_source_select  = regs[`IDX_FB_SRC][7:0];
    assign status = {13'h0000, 3'(q.state), q.pid_out};
    // Sleep count restarts on entry to RUN so a bypass never shortens it
endmodule

// ===== pid_cfg.svh
`ifndef PID_CFG_SVH
`define PID_CFG_SVH
// Notes on behaviour
// - P term is error times gain percent
// - Gain scale gives ratios below 0.1 percent
// - Integral reaches 100 percent after integral time
// - Integral clear input zeroes the accumulator
// - D term is error slope times derivative time
// - Reference times feedforward gain added to output
// - Low-pass filter, zero means no smoothing
// - Output clamped between upper and lower limits
// - Output multiplied by output scale factor
// - Prestage runs open-loop until feedback exceeds exit
// - Prestage timeout raises fault and blocks output
// - Low frequency for sleep delay enters sleep
// - Wake mode 0: feedback below wake level
// - Wake mode 1: feedback above wake level
// - Wake mode 2: error beyond wake level
// - Loop bypass input forces general operation except in fault
// - Loop works only with process control code
// - Feedback source equal to reference is rejected

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     8
`define SAMPLE_PERIOD_NS  1000000

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define NUM_REGS          24
`define IDX_APP           0
`define IDX_REF_SRC       1
`define IDX_FB_SRC        2
`define IDX_KP            3
`define IDX_TI            4
`define IDX_TD            5
`define IDX_FF            6
`define IDX_KP_SCALE      7
`define IDX_LPF           8
`define IDX_HI            9
`define IDX_LO            10
`define IDX_OUT_SCALE     11
`define IDX_PRE_FREQ      12
`define IDX_PRE_EXIT      13
`define IDX_PRE_DELAY     14
`define IDX_SLEEP_DELAY   15
`define IDX_SLEEP_FREQ    16
`define IDX_WAKE_LEVEL    17
`define IDX_WAKE_MODE     18
`define IDX_ALT_GAIN      19
`define IDX_ALT_TI        20
`define IDX_TERM_FUNC     21
`define IDX_STATUS        22

// ****************************************
// Codes, scales and reset values
// ****************************************
`define APP_PROCESS       16'h0002
`define FUNC_I_CLEAR      6'h15
`define FUNC_BYPASS       6'h17
`define FUNC_ALT_GAIN     6'h18
`define TERM_FUNC_W       6
`define GAIN_DEN          64'sh3e8
`define KP_SCALE_DEN      64'sh64
`define WAKE_BELOW        2'h0
`define WAKE_ABOVE        2'h1
`define WAKE_BEYOND       2'h2
`define RST_KP            32'h000003e8
`define RST_TI            32'h000003e8
`define RST_KP_SCALE      32'h00000064
`define RST_HI            32'h00002710
`define RST_OUT_SCALE     32'h000003e8
`define RST_APP           32'h00000002
`define RST_FB_SRC        32'h00000001
`endif

// ===== pid_pkg.sv
`include "pid_cfg.svh"
package pid_pkg;
    typedef logic [`NUM_REGS-1:0][31:0] reg_bank_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_PRESTAGE, ST_RUN, ST_SLEEP, ST_GENERAL, ST_FAULT
    } loop_state_e;
endpackage

// ===== term_sync.sv
`timescale 1ns/10ps
module term_sync #(
    parameter int W = 5
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] levels
);
    import pid_pkg::*;
    initial if (W < 1) $error("term_sync width must be positive");

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s q;
    sync_s d;

    // A bit changes only once the second and third stages agree
    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign levels = q.lvl;
endmodule

// ===== reg_slave.sv
`timescale 1ns/10ps
`include "pid_cfg.svh"
module reg_slave (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [31:0]       status,
    output pid_pkg::reg_bank_t     regs
);
    import pid_pkg::*;

    function automatic logic [31:0] reset_value(input int i);
        case (i)
            `IDX_APP:       reset_value = `RST_APP;
            `IDX_FB_SRC:    reset_value = `RST_FB_SRC;
            `IDX_KP:        reset_value = `RST_KP;
            `IDX_TI:        reset_value = `RST_TI;
            `IDX_KP_SCALE:  reset_value = `RST_KP_SCALE;
            `IDX_HI:        reset_value = `RST_HI;
            `IDX_OUT_SCALE: reset_value = `RST_OUT_SCALE;
            default:        reset_value = 32'h00000000;
        endcase
    endfunction

    typedef struct packed {
        reg_bank_t   bank;
        logic        aw_have;
        logic [4:0]  aw_idx;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } slave_s;

    slave_s q;
    slave_s d;
    logic [4:0]  ar_idx;
    logic [31:0] merged;

    assign ar_idx = s_axi_araddr[6:2];
    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready  = !q.w_have && !q.bvalid;
    assign s_axi_arready = !q.rvalid;

    always_comb begin
        d = q;
        merged = q.bank[q.aw_idx];
        for (int b = 0; b < 4; b++) begin
            if (q.wstrb[b]) begin
                merged[8*b +: 8] = q.wdata[8*b +: 8];
            end
        end
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.aw_idx  = s_axi_awaddr[6:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = 2'h0;
            if (q.aw_idx >= 5'(`IDX_STATUS)) begin
                d.bresp = 2'h2;
            end else if (q.aw_idx == 5'(`IDX_FB_SRC) &&
                         merged == q.bank[`IDX_REF_SRC]) begin
                d.bresp = 2'h2;
            end else if (q.aw_idx == 5'(`IDX_REF_SRC) &&
                         merged == q.bank[`IDX_FB_SRC]) begin
                d.bresp = 2'h2;
            end else begin
                d.bank[q.aw_idx] = merged;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = 2'h0;
            d.rdata  = 32'h00000000;
            if (ar_idx < 5'(`IDX_STATUS)) begin
                d.rdata = q.bank[ar_idx];
            end else if (ar_idx == 5'(`IDX_STATUS)) begin
                d.rdata = status;
            end else begin
                d.rresp = 2'h2;
            end
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        d.bank[`IDX_STATUS] = 32'h00000000;
        d.bank[`NUM_REGS-1] = 32'h00000000;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            for (int i = 0; i < `NUM_REGS; i++) begin
                q.bank[i] <= reset_value(i);
            end
        end else begin
            q <= d;
        end
    end

    assign regs         = q.bank;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp  = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp  = q.rresp;
    assign s_axi_rdata  = q.rdata;
endmodule

// ===== pid_checker.sv
`timescale 1ns/10ps
// ****************************************
// Port checks of the loop controller
// ****************************************
module pid_checker (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               run_cmd,
    input wire logic signed [15:0] freq_cmd,
    input wire logic               output_block,
    input wire logic               prestage_timeout_fault,
    input wire logic               sleeping,
    input wire logic [7:0]         reference_source_select,
    input wire logic [7:0]         feedback_source_select,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_FAULT_BLOCK: assert property (output_block == prestage_timeout_fault)
        else $error("block and fault differ");
    AST_FAULT_ZERO: assert property (prestage_timeout_fault [*2] |-> freq_cmd == 0)
        else $error("output not blocked in fault");
    AST_FAULT_HOLD: assert property (prestage_timeout_fault && run_cmd |=> prestage_timeout_fault)
        else $error("fault left while running");
    AST_SLEEP_ZERO: assert property (sleeping [*2] |-> freq_cmd == 0)
        else $error("output running in sleep");
    AST_FAULT_RUN: assert property ($rose(output_block) |-> $past(run_cmd))
        else $error("fault raised without run command");
    // The stop-clear check allows one edge for the state to settle, the stop-zero check two
    AST_STOP_ZERO: assert property (!run_cmd ##1 !run_cmd |=> freq_cmd == 0)
        else $error("output without run command");
    AST_STOP_CLEAR: assert property (!run_cmd |=> !sleeping && !output_block)
        else $error("state kept after stop");
    AST_SRC_DIFF: assert property (reference_source_select != feedback_source_select)
        else $error("sources equal");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
endmodule

// ===== process_sensor.sv
`timescale 1ns/10ps
// ****************************************
// Sensors and reference inputs
// ****************************************
module process_sensor #(
    parameter logic signed [15:0] GEN = 16'sh04d2
) (
    input  wire logic               aclk,
    input  wire logic signed [15:0] fb_level,
    input  wire logic signed [15:0] ref_level,
    output logic signed [15:0]      reference,
    output logic signed [15:0]      feedback,
    output logic signed [15:0]      general_freq
);
    // One cycle of sensor lag, so the loop never sees a level early
    always_ff @(posedge aclk) begin
        reference    <= ref_level;
        feedback     <= fb_level;
        general_freq <= GEN;
    end
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
// ****************************************
// Self-checking bench
// ****************************************
module testbench;
    localparam int              SC  = 8;
    localparam logic signed [15:0] GEN = 16'sh04d2;
    logic               aclk = 0, aresetn = 0, run_cmd = 0;
    logic [7:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]        s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]         s_axi_wstrb = 4'hf;
    logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic               s_axi_arvalid = 0, s_axi_rready = 0;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic [4:0]         term_pins = 0;
    logic signed [15:0] fb_level = 0, ref_level = 0;
    logic signed [15:0] reference, feedback, general_freq, freq_cmd;
    logic               output_block, prestage_timeout_fault, sleeping;
    logic [7:0]         reference_source_select, feedback_source_select;
    int                 n_errors = 0, n_compared = 0, cyc = 0;
    pid_loop_control #(.SAMPLE_CYCLES(SC)) i_dut (.*);
    process_sensor #(.GEN(GEN)) i_sensor (.*);
    always #4 aclk = ~aclk;
    task automatic close_out;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard: whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n * SC) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        // Late bready keeps the answer waiting one cycle
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    task automatic t_regs;
        rd(8'h0c, 32'h3e8, 2'h0);
        rd(8'h00, 32'h2, 2'h0);
        wr(8'h58, 32'h0, 2'h2);
        wr(8'h08, 32'h0, 2'h2);
        rd(8'h08, 32'h1, 2'h0);
        rd(8'h5c, 32'h0, 2'h2);
    endtask
    task automatic t_run;
        wr(8'h0c, 32'h1f4, 2'h0);
        wr(8'h10, 32'h0, 2'h0);
        wr(8'h30, 32'h64, 2'h0);
        wr(8'h34, 32'h3e8, 2'h0);
        ref_level <= 16'sh1770;
        run_cmd   <= 1'b1;
        ticks(4);
        chk(32'(freq_cmd), 32'h64);
        fb_level <= 16'sh07d0;
        ticks(6);
        chk(32'(freq_cmd), 32'h7d0);
        wr(8'h24, 32'h5dc, 2'h0);
        ticks(4);
        chk(32'(freq_cmd), 32'h5dc);
        wr(8'h2c, 32'h1f4, 2'h0);
        ticks(4);
        chk(32'(freq_cmd), 32'h2ee);
        wr(8'h1c, 32'h32, 2'h0);
        ticks(4);
        chk(32'(freq_cmd), 32'h1f4);
    endtask
    task automatic t_bypass;
        wr(8'h54, 32'h17, 2'h0);
        term_pins <= 5'h01;
        ticks(2);
        chk(32'(freq_cmd), 32'(GEN));
        term_pins <= 5'h00;
        ticks(4);
        chk(32'(freq_cmd), 32'h1f4);
    endtask
    task automatic t_sleep;
        wr(8'h48, 32'h1, 2'h0);
        wr(8'h44, 32'h1388, 2'h0);
        wr(8'h40, 32'h3e8, 2'h0);
        wr(8'h3c, 32'h2, 2'h0);
        ticks(5);
        chk(32'(sleeping), 32'h1);
        fb_level <= 16'sh1770;
        ticks(1);
        chk(32'(sleeping), 32'h0);
        wr(8'h48, 32'h0, 2'h0);
        ticks(3);
        chk(32'(sleeping), 32'h1);
        fb_level <= 16'sh0bb8;
        ticks(1);
        chk(32'(sleeping), 32'h0);
        wr(8'h48, 32'h2, 2'h0);
        ticks(3);
        chk(32'(sleeping), 32'h1);
        fb_level <= 16'sh0000;
        ticks(1);
        chk(32'(sleeping), 32'h0);
        run_cmd <= 1'b0;
        wr(8'h3c, 32'h0, 2'h0);
    endtask
    task automatic t_fault;
        fb_level <= 16'sh0000;
        wr(8'h38, 32'h3, 2'h0);
        run_cmd <= 1'b1;
        ticks(6);
        chk(32'(output_block), 32'h1);
        chk(32'(freq_cmd), 32'h0);
        run_cmd <= 1'b0;
        ticks(1);
        chk(32'(output_block), 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_run;
        t_bypass;
        t_sleep;
        t_fault;
        close_out;
    end
endmodule
bind pid_loop_control pid_checker i_chk (.*);
